// >>> hdl/lsm_lane_pick.sv
// combinational byte-lane selection
module lsm_lane_pick (
   lsm_mem_if.picker lp
);
   logic [7:0] baseMask;
   logic [7:0] lsbMask;
   logic [3:0] hiLane;

   // lanes covered, from lowest address byte upward
   always_comb begin
      baseMask = lsm_pkg::lsmSizeMask(lp.access_size_code);
      lsbMask = baseMask << lp.lowAddr;
      hiLane = 4'h7 - ({1'b0, lp.lowAddr} + {1'b0, lp.access_size_code});
      // big endian: lowest address is the most significant lane
      if (lp.load_store_big_endian) begin
         lp.laneMask = baseMask << hiLane[2:0];
      end else begin
         lp.laneMask = lsbMask;
      end
   end
endmodule

// >>> hdl/lsm_mem_if.sv
// request and answer between the unit and its lane picker
interface lsm_mem_if;
   logic [2:0] lowAddr;
   logic [2:0] access_size_code;
   logic load_store_big_endian;
   logic [7:0] laneMask;
   modport unit (output lowAddr, output access_size_code, output load_store_big_endian, input laneMask);
   modport picker (input lowAddr, input access_size_code, input load_store_big_endian, output laneMask);
endinterface

// >>> hdl/lsm_pkg.sv
// Operation
// - load returns one aligned register-wide element
// - lanes from low address bits and size
// - access resolved by policy and source
// - uncached load reads only referenced bytes
// - cached miss fills aligned block, element minimum
// - store changes only selected byte lanes
// - size code is byte count minus one
// - prefetch never changes visible state
// - sync orders loads and stores globally
// - object address is its lowest byte
// - byte order is memory endianness xor flip
package lsm_pkg;
   localparam int ELEM_BYTES = 8;              // register-wide element, 64 bits
   localparam int ELEM_BITS = 64;
   localparam int ADDR_BITS = 32;
   localparam int LANE_BITS = 3;               // low address bits picking a lane
   localparam int BLOCK_WORDS = 4;             // cached fill block, in elements
   localparam logic [2:0] SIZE_BYTE = 3'h0;
   localparam logic [2:0] SIZE_HALF = 3'h1;
   localparam logic [2:0] SIZE_TRIPLE = 3'h2;
   localparam logic [2:0] SIZE_WORD = 3'h3;
   localparam logic [2:0] SIZE_QUINT = 3'h4;
   localparam logic [2:0] SIZE_SEXT = 3'h5;
   localparam logic [2:0] SIZE_SEPT = 3'h6;
   localparam logic [2:0] SIZE_DOUBLE = 3'h7;
   localparam logic [2:0] POLICY_UNCACHED = 3'h2; // coherence policy code for uncached
   localparam logic [1:0] OP_LOAD = 2'h0;
   localparam logic [1:0] OP_STORE = 2'h1;
   localparam logic [1:0] OP_PREFETCH = 2'h2;
   localparam logic [1:0] OP_SYNC = 2'h3;
   localparam logic [1:0] FILL_CNT_LAST = 2'h3; // last element index of a fill
   typedef enum {ST_IDLE, ST_MEM, ST_FILL, ST_DRAIN} lsm_state_t;

   // byte count minus one gives enable mask starting at lane 0
   function automatic logic [7:0] lsmSizeMask(input logic [2:0] code);
      lsmSizeMask = 8'hff >> (3'h7 - code);
   endfunction
endpackage

// >>> hdl/lsm_unit.sv
// load/store memory access port
module lsm_unit (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clkEn,
   // endianness configuration
   input wire logic memory_big_endian,
   input wire logic user_endian_flip,
   // pipeline request
   input wire logic reqValid,
   input wire logic [1:0] reqOp,
   input wire logic [lsm_pkg::ADDR_BITS-1:0] virtual_addr,
   input wire logic [lsm_pkg::ADDR_BITS-1:0] physAddr,
   input wire logic [2:0] coherence_policy,
   input wire logic instr_or_data_sel,
   input wire logic [2:0] access_size_code,
   input wire logic [lsm_pkg::ELEM_BITS-1:0] storeData,
   output logic reqReady,
   // pipeline answer
   output logic rspValid,
   output logic [lsm_pkg::ELEM_BITS-1:0] loadElem,
   output logic [7:0] loadLanes,
   // memory side
   output logic memReq,
   output logic memWrite,
   output logic memFill,
   output logic memSync,
   output logic memInstr,
   output logic [lsm_pkg::ADDR_BITS-1:0] memAddr,
   output logic [7:0] memByteEn,
   output logic [lsm_pkg::ELEM_BITS-1:0] memWdata,
   input wire logic memAck,
   input wire logic [lsm_pkg::ELEM_BITS-1:0] memRdata,
   // cache side
   input wire logic cacheHit,
   input wire logic [lsm_pkg::ELEM_BITS-1:0] cacheRdata,
   output logic cacheFillWe,
   output logic [lsm_pkg::ADDR_BITS-1:0] cacheFillAddr,
   output logic [lsm_pkg::ELEM_BITS-1:0] cacheFillData
);
   // lane picker interface, driven from the live request pins
   lsm_mem_if lane ();
   lsm_pkg::lsm_state_t state_q;
   logic bigEndian;                      // effective load/store order
   logic uncached;
   logic [1:0] fillCnt_q;                // element within fill block
   logic [7:0] reqLanes_q;               // lanes of pending load
   // request captured at the taking edge
   logic [lsm_pkg::ADDR_BITS-1:0] reqAddr_q;
   logic [2:0] reqSize_q;

   // effective order and policy decode from live request pins
   assign bigEndian = memory_big_endian ^ user_endian_flip;
   assign uncached = coherence_policy == lsm_pkg::POLICY_UNCACHED;
   assign lane.lowAddr = physAddr[lsm_pkg::LANE_BITS-1:0];
   assign lane.access_size_code = access_size_code;
   assign lane.load_store_big_endian = bigEndian;

   // lane choice is combinational so a hit answers next cycle
   // the same mask serves the load answer and the store enables
   lsm_lane_pick picker (
      .lp(lane)
   );

   // sequencer; one request at a time keeps order trivially global
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // nothing owed to memory or pipeline after reset
         state_q <= lsm_pkg::ST_IDLE;
         reqReady <= 1'b0;
         rspValid <= 1'b0;
         loadElem <= 64'h0;
         loadLanes <= 8'h00;
         memReq <= 1'b0;
         memWrite <= 1'b0;
         memFill <= 1'b0;
         memSync <= 1'b0;
         memInstr <= 1'b0;
         memAddr <= 32'h0;
         memByteEn <= 8'h00;
         memWdata <= 64'h0;
         fillCnt_q <= 2'h0;
         reqLanes_q <= 8'h00;
         reqAddr_q <= 32'h0;
         reqSize_q <= 3'h0;
      end else if (clkEn) begin
         // answer pulse falls unless set again below
         rspValid <= 1'b0;
         case (state_q)
            lsm_pkg::ST_IDLE: begin
               // ready stays up while idle; hits and prefetches keep it
               reqReady <= 1'b1;
               if (reqValid && reqReady) begin
                  reqReady <= 1'b0;
                  reqAddr_q <= physAddr;
                  reqSize_q <= access_size_code;
                  reqLanes_q <= lane.laneMask;
                  memInstr <= instr_or_data_sel;
                  case (reqOp)
                     lsm_pkg::OP_LOAD: begin
                        if (!uncached && cacheHit) begin
                           // hit answers at once, whole aligned element
                           rspValid <= 1'b1;
                           loadElem <= cacheRdata;
                           loadLanes <= lane.laneMask;
                           reqReady <= 1'b1;
                        end else if (uncached) begin
                           // only referenced bytes are fetched
                           memReq <= 1'b1;
                           memWrite <= 1'b0;
                           memFill <= 1'b0;
                           memAddr <= {physAddr[31:3], 3'h0};
                           memByteEn <= lane.laneMask;
                           state_q <= lsm_pkg::ST_MEM;
                        end else begin
                           // miss: fill an aligned block of elements
                           memReq <= 1'b1;
                           memWrite <= 1'b0;
                           memFill <= 1'b1;
                           memAddr <= {physAddr[31:5], 5'h0};
                           memByteEn <= 8'hff;
                           fillCnt_q <= 2'h0;
                           state_q <= lsm_pkg::ST_FILL;
                        end
                     end
                     lsm_pkg::OP_STORE: begin
                        // unused lanes pass through, enables keep memory safe
                        memReq <= 1'b1;
                        memWrite <= 1'b1;
                        memFill <= 1'b0;
                        memAddr <= {physAddr[31:3], 3'h0};
                        memByteEn <= lane.laneMask;
                        memWdata <= storeData;
                        state_q <= lsm_pkg::ST_MEM;
                     end
                     lsm_pkg::OP_PREFETCH: begin
                        // advisory: dropped, no visible state touched
                        reqReady <= 1'b1;
                     end
                     default: begin
                        // sync waits until memory confirms all prior effects
                        memReq <= 1'b1;
                        memSync <= 1'b1;
                        memWrite <= 1'b0;
                        memFill <= 1'b0;
                        memByteEn <= 8'h00;
                        state_q <= lsm_pkg::ST_DRAIN;
                     end
                  endcase
               end
            end
            lsm_pkg::ST_MEM: begin
               // waits for the one ack of an uncached load or a store
               if (memAck) begin
                  memReq <= 1'b0;
                  reqReady <= 1'b1;
                  state_q <= lsm_pkg::ST_IDLE;
                  // every finished access is answered, stores too
                  rspValid <= 1'b1;
                  if (!memWrite) begin
                     loadElem <= memRdata;
                     loadLanes <= reqLanes_q;
                  end
               end
            end
            lsm_pkg::ST_FILL: begin
               // four beats, address steps one element per ack
               if (memAck) begin
                  // requested element forwarded when it passes
                  if (memAddr[4:3] == reqAddr_q[4:3]) begin
                     rspValid <= 1'b1;
                     loadElem <= memRdata;
                     loadLanes <= reqLanes_q;
                  end
                  if (fillCnt_q == lsm_pkg::FILL_CNT_LAST) begin
                     memReq <= 1'b0;
                     memFill <= 1'b0;
                     reqReady <= 1'b1;
                     state_q <= lsm_pkg::ST_IDLE;
                  end else begin
                     fillCnt_q <= fillCnt_q + 2'h1;
                     memAddr <= memAddr + 32'h8;
                  end
               end
            end
            lsm_pkg::ST_DRAIN: begin
               // pipeline stalls until memory reports all earlier effects visible
               if (memAck) begin
                  memReq <= 1'b0;
                  memSync <= 1'b0;
                  reqReady <= 1'b1;
                  // completion pulse lets the pipeline resume in order
                  rspValid <= 1'b1;
                  state_q <= lsm_pkg::ST_IDLE;
               end
            end
            default: begin
               // unreachable encodings fall back to idle
               state_q <= lsm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // fill write port toward the cache, one pulse per returned element
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cacheFillWe <= 1'b0;
         cacheFillAddr <= 32'h0;
         cacheFillData <= 64'h0;
      end else if (clkEn) begin
         cacheFillWe <= state_q == lsm_pkg::ST_FILL && memAck;
         // data and address only move on a beat, so they hold for the cache
         if (state_q == lsm_pkg::ST_FILL && memAck) begin
            cacheFillAddr <= memAddr;
            cacheFillData <= memRdata;
         end
      end
   end
endmodule

// >>> verification/lsm_mem_model.sv
// main memory behind the unit, element-wide, with a set wait
module lsm_mem_model (
   // clock and request
   input wire logic clk_sys,
   input wire logic memReq,
   input wire logic memWrite,
   input wire logic [31:0] memAddr,
   input wire logic [7:0] memByteEn,
   input wire logic [63:0] memWdata,
   input wire logic [3:0] ackDelay,
   // answer
   output logic memAck,
   output logic [63:0] memRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [63:0] mem [int]; // elements accessed so far, reads included
   int waitCnt = 0;
   initial memAck = 1'b0;
   initial memRdata = 64'h0;
   // one ack per beat after the wait; data never holds outside an ack
   always @(posedge clk_sys) begin
      int key;
      logic [63:0] e;
      key = int'(memAddr[31:3]);
      e = mem.exists(key) ? mem[key] : {~key, key};
      memRdata <= ~memRdata;
      if (memAck || !memReq) begin
         memAck <= 1'b0;
         waitCnt <= 0;
      end else if (waitCnt >= ackDelay) begin
         // writes land before the ack, so a sync ack sees them all
         memAck <= 1'b1;
         memRdata <= e;
         for (int i = 0; i < 8; i++) if (memWrite && memByteEn[i]) e[8*i +: 8] = memWdata[8*i +: 8];
         mem[key] = e;
      end else waitCnt <= waitCnt + 1;
   end
endmodule

// >>> verification/lsm_unit_props.sv
// checker on the unit's pipeline and memory ports
module lsm_unit_props (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // pipeline side
   input wire logic reqValid,
   input wire logic reqReady,
   input wire logic [1:0] reqOp,
   input wire logic [2:0] coherence_policy,
   input wire logic instr_or_data_sel,
   input wire logic cacheHit,
   input wire logic rspValid,
   // cache fill side
   input wire logic cacheFillWe,
   input wire logic [lsm_pkg::ADDR_BITS-1:0] cacheFillAddr,
   input wire logic [lsm_pkg::ELEM_BITS-1:0] cacheFillData,
   // memory side
   input wire logic memReq,
   input wire logic memAck,
   input wire logic memWrite,
   input wire logic memFill,
   input wire logic memSync,
   input wire logic memInstr,
   input wire logic [lsm_pkg::ADDR_BITS-1:0] memAddr,
   input wire logic [7:0] memByteEn,
   input wire logic [lsm_pkg::ELEM_BITS-1:0] memRdata
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // request accepted at this edge
   sequence sTaken(logic [1:0] op);
      reqValid && reqReady && reqOp == op;
   endsequence
   // cached load, hit or miss
   sequence sCachedLoad(logic hit);
      sTaken(lsm_pkg::OP_LOAD) ##0 cacheHit == hit && coherence_policy != lsm_pkg::POLICY_UNCACHED;
   endsequence
   a_req_held: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memByteEn))
      else $error("memory request changed before ack");
   a_addr_aligned: assert property (memReq |-> memAddr[2:0] == 3'h0) else $error("element address unaligned");
   a_busy_refuse: assert property (memReq |-> !reqReady) else $error("ready while busy");
   a_ack_answer: assert property (memAck && memReq && !memFill |=> rspValid) else $error("no answer after ack");
   a_hit_answer: assert property (sCachedLoad(1'b1) |=> rspValid && !memReq) else $error("hit not answered");
   a_miss_fill: assert property (sCachedLoad(1'b0) |=> ##[0:2] memReq && memFill && memAddr[4:0] == 5'h0)
      else $error("miss without block fill");
   a_prefetch_quiet: assert property (sTaken(lsm_pkg::OP_PREFETCH) |=> !memReq) else $error("prefetch touched memory");
   a_sync_kind: assert property (memReq && memSync |-> !memWrite && !memFill) else $error("sync mixed with data");
   a_store_lanes: assert property (memReq && memWrite |-> memByteEn != 8'h0 && !memFill) else $error("store lanes bad");
   a_instr_kept: assert property (reqValid && reqReady |=> memInstr == $past(instr_or_data_sel))
      else $error("access source not carried");
   a_fill_write: assert property (memAck && memReq && memFill |=> cacheFillWe && cacheFillAddr == $past(memAddr))
      else $error("fill beat not written");
   a_fill_data: assert property (memAck && memReq && memFill |=> cacheFillData == $past(memRdata))
      else $error("fill data not written");
endmodule
bind lsm_unit lsm_unit_props u_props (.clk_sys, .rst, .reqValid, .reqReady, .reqOp, .coherence_policy,
   .instr_or_data_sel, .cacheHit, .rspValid, .cacheFillWe, .cacheFillAddr, .cacheFillData, .memReq, .memAck,
   .memWrite, .memFill, .memSync, .memInstr, .memAddr, .memByteEn, .memRdata);

// >>> verification/test_lsm_unit.sv
// self-checking bench: shadow memory of elements against the unit
module test_lsm_unit;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, rst = 1'b1, memory_big_endian = 1'b0, user_endian_flip = 1'b0, reqValid = 1'b0;
   logic instr_or_data_sel = 1'b0, cacheHit = 1'b0;
   logic [1:0] reqOp = 2'h0;
   logic [31:0] physAddr = 32'h0, memAddr;
   logic [2:0] coherence_policy = 3'h0, access_size_code = 3'h0;
   logic [63:0] storeData = 64'h0, cacheRdata = 64'h0, loadElem, memWdata, memRdata;
   logic [3:0] ackDelay = 4'h0;
   logic reqReady, rspValid, memReq, memWrite, memFill, memSync, memAck;
   logic [7:0] loadLanes, memByteEn;
   logic [63:0] sh [int]; // expected memory contents
   int errors = 0, n_tests = 0;
   always #25 clk_sys = ~clk_sys;
   lsm_unit dut (.clk_sys, .rst, .clkEn(1'b1), .memory_big_endian, .user_endian_flip, .reqValid, .reqOp,
      .virtual_addr(physAddr), .physAddr, .coherence_policy, .instr_or_data_sel, .access_size_code, .storeData,
      .reqReady, .rspValid, .loadElem, .loadLanes, .memReq, .memWrite, .memFill, .memSync, .memInstr(), .memAddr,
      .memByteEn, .memWdata, .memAck, .memRdata, .cacheHit, .cacheRdata, .cacheFillWe(), .cacheFillAddr(),
      .cacheFillData());
   lsm_mem_model mem (.clk_sys, .memReq, .memWrite, .memAddr, .memByteEn, .memWdata, .ackDelay, .memAck, .memRdata);
   // counted compare
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bounded wait for a level sampled at the edge; running out is a mismatch
   task automatic waitHi(ref logic s);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (s !== 1'b1 && n < 99);
      if (s !== 1'b1) chk(64'(s), 64'h1);
   endtask
   // one request, held until taken, then its answer checked
   task automatic doOp(input logic [1:0] op, input logic [2:0] pol, input logic hit, input logic [2:0] sz,
                       input int k, input logic [2:0] off);
      logic be, mb;
      logic [7:0] m;
      logic [63:0] bm, hd, sd, cur;
      mb = 1'($urandom);
      be = mb ^ 1'($urandom);
      hd = {$urandom, $urandom};
      sd = {$urandom, $urandom};
      cur = sh.exists(k) ? sh[k] : {~k, k};
      m = 8'((9'h1 << (4'(sz) + 4'h1)) - 9'h1);
      m = m << (be ? 3'h7 - off - sz : off);
      for (int i = 0; i < 8; i++) bm[8*i +: 8] = {8{m[i]}};
      @(posedge clk_sys);
      memory_big_endian <= mb;
      user_endian_flip <= mb ^ be;
      reqValid <= 1'b1;
      reqOp <= op;
      coherence_policy <= pol;
      physAddr <= {k[28:0], off};
      access_size_code <= sz;
      cacheHit <= hit;
      instr_or_data_sel <= 1'($urandom);
      cacheRdata <= hd;
      storeData <= sd;
      ackDelay <= 4'($urandom % 6);
      waitHi(reqReady);
      reqValid <= 1'b0;
      if (op == lsm_pkg::OP_PREFETCH) repeat (2) @(posedge clk_sys);
      else begin
         waitHi(rspValid);
         chk(64'(rspValid), 64'h1);
         if (op == lsm_pkg::OP_STORE) sh[k] = (cur & ~bm) | (sd & bm);
         if (op == lsm_pkg::OP_LOAD) begin
            chk(64'(loadLanes), 64'(m));
            if (pol == lsm_pkg::POLICY_UNCACHED) chk(loadElem & bm, cur & bm);
            else chk(loadElem, hit ? hd : cur);
         end
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard well past the expected run
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      test_done;
   end
   initial begin
      int k;
      logic [2:0] o, s;
      void'($urandom(32'h685d));
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      // every size code: uncached store then read back, byte order random
      for (int z = 0; z < 8; z++) begin
         k = $urandom % 16;
         o = 3'($urandom % (8 - z));
         doOp(lsm_pkg::OP_STORE, lsm_pkg::POLICY_UNCACHED, 1'b0, 3'(z), k, o);
         doOp(lsm_pkg::OP_LOAD, lsm_pkg::POLICY_UNCACHED, 1'b0, 3'(z), k, o);
      end
      $display("size sweep done");
      // mix of hits, fills, stores, syncs and prefetches with slow memory
      repeat (80) begin
         s = 3'($urandom);
         o = 3'($urandom % (8 - s));
         doOp(2'($urandom), 3'($urandom), 1'($urandom), s, $urandom % 16, o);
      end
      $display("random mix done");
      test_done;
   end
endmodule
